// [hpi_host_port.sv]
// Host processor port: parallel (two strobe styles) or SPI slave access
// to 8-bit registers, completion output and configurable interrupt pin.
// Assumes the register file answers i_reg_rdata in the cycle after
// o_reg_rd; pins are asynchronous and synchronised here.
`timescale 1ns/1ps
// How it works
// - Shared pins carry 8-bit data both ways
// - Multiplexed modes take low address from shared pins
// - Completion output goes low when access done
// - Interrupt pin polarity is selectable
// - Interrupt pin push-pull or open-drain
// - Interrupt pin may be software general output
// - SPI read data leaves only on serial output
// - Phase picks leading or trailing sample edge
// - Polarity picks serial clock idle level
// - Select straps caught at reset fix style
// - Latch enable captures address per mode
// - Data strobe: drive on fall, capture rise
module hpi_host_port (
  input  wire logic                       i_mclk,
  input  wire logic                       i_reset_n,
  input  wire logic                       i_clk_en,
  input  wire logic [2:0]                 i_bus_style_select,
  input  wire hpi_pkg::hpi_par_pins_t     i_par,
  input  wire hpi_pkg::hpi_spi_pins_t     i_spi,
  input  wire hpi_pkg::hpi_irq_cfg_t      i_irq_pin_config,
  input  wire logic                       i_irq_event,
  input  wire logic [hpi_pkg::DATA_W-1:0] i_reg_rdata,
  output logic [2:0]                      o_bus_style,
  output logic [hpi_pkg::DATA_W-1:0]      o_ad,
  output logic                            o_ad_oe,
  output logic                            o_ready_n,
  output logic                            o_sdo,
  output logic                            o_sdo_oe,
  output logic                            o_irq_output,
  output logic                            o_irq_oe,
  output logic [hpi_pkg::ADDR_W-1:0]      o_reg_addr,
  output logic [hpi_pkg::DATA_W-1:0]      o_reg_wdata,
  output logic                            o_reg_wr,
  output logic                            o_reg_rd
);
  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic is_spi(input logic [2:0] s);
    is_spi = (s == hpi_pkg::STYLE_SPI_LSB) || (s == hpi_pkg::STYLE_SPI_MSB);
  endfunction : is_spi
  function automatic logic is_ds(input logic [2:0] s);
    is_ds = (s == hpi_pkg::STYLE_DS_DIR) || (s == hpi_pkg::STYLE_DS_MUX);
  endfunction : is_ds
  function automatic logic is_mux(input logic [2:0] s);
    is_mux = (s == hpi_pkg::STYLE_SEP_MUX) || (s == hpi_pkg::STYLE_DS_MUX);
  endfunction : is_mux
  // Frame position of serial bit k in either bit order
  function automatic logic [4:0] bit_pos(input logic [4:0] k,
                                         input logic       lsb);
    if (!lsb) bit_pos = 5'h17 - k;
    else if (k < hpi_pkg::HDR_BITS) bit_pos = k + 5'h08;
    else bit_pos = k - hpi_pkg::HDR_BITS;
  endfunction : bit_pos

  // ----------------------------------------------------------------------
  // Synchronised pins
  // ----------------------------------------------------------------------
  hpi_pkg::hpi_par_pins_t par_s;
  hpi_pkg::hpi_spi_pins_t spi_s;
  logic [2:0]             style_s;

  hpi_sync #(.WIDTH($bits(i_par) + $bits(i_spi) + 3)) u_sync (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_clk_en  (i_clk_en),
    .i_async   ({i_par, i_spi, i_bus_style_select}),
    .o_sync    ({par_s, spi_s, style_s})
  );

  // ----------------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------------
  logic [1:0] strap_cnt_reg, strap_cnt_next;
  logic [2:0] style_reg, style_next;
  logic       spi_mode, ds_mode, par_mode;

  // Waits out the synchroniser after release, then freezes the style
  always_comb begin
    strap_cnt_next = strap_cnt_reg;
    style_next     = style_reg;
    if (strap_cnt_reg != hpi_pkg::STRAP_WAIT) begin
      strap_cnt_next = strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == hpi_pkg::STRAP_WAIT - 2'h1)
        style_next = style_s;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      strap_cnt_reg <= 2'h0;
      style_reg     <= 3'h0;
    end else if (i_clk_en) begin
      strap_cnt_reg <= strap_cnt_next;
      style_reg     <= style_next;
    end
  end

  assign spi_mode = is_spi(style_reg);
  assign ds_mode  = is_ds(style_reg);
  // Unused codes leave the port dead
  assign par_mode = (style_reg[2] | style_reg[1]) & ~spi_mode;

  // ----------------------------------------------------------------------
  // Parallel port
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    P_IDLE, P_FETCH, P_WAIT, P_RHOLD, P_WHOLD, P_DSWR
  } hpi_par_state_t;
  hpi_par_state_t        p_state_reg, p_state_next;
  logic [hpi_pkg::ADDR_W-1:0] p_addr_reg, p_addr_next;
  logic [hpi_pkg::DATA_W-1:0] p_wdata_reg, p_wdata_next;
  logic [hpi_pkg::DATA_W-1:0] ad_next;
  logic                  ad_oe_next, ready_n_next;
  logic                  p_rd_req, p_wr_req, strobe_on;

  // One transfer at a time; the strobe must go away before the next
  always_comb begin
    p_state_next = p_state_reg;
    p_addr_next  = p_addr_reg;
    p_wdata_next = p_wdata_reg;
    ad_next      = o_ad;
    ad_oe_next   = o_ad_oe;
    ready_n_next = o_ready_n;
    p_rd_req     = 1'b0;
    p_wr_req     = 1'b0;
    strobe_on    = ~par_s.cs_n & (~par_s.rds_n | (~ds_mode & ~par_s.wr_n));
    if (par_s.ale) begin
      if (is_mux(style_reg))
        p_addr_next = {par_s.addr[8], par_s.ad};
      else
        p_addr_next = par_s.addr;
    end
    case (p_state_reg)
      P_IDLE: begin
        if (par_mode && strobe_on) begin
          if (ds_mode && !par_s.wr_n) begin
            p_state_next = P_DSWR;
          end else if (ds_mode || !par_s.rds_n) begin
            p_rd_req     = 1'b1;
            p_state_next = P_FETCH;
          end else begin
            p_wr_req     = 1'b1;
            p_wdata_next = par_s.ad;
            p_state_next = P_WHOLD;
            ready_n_next = 1'b0;
          end
        end
      end
      P_FETCH: p_state_next = P_WAIT;
      P_WAIT: begin
        ad_next      = i_reg_rdata;
        ad_oe_next   = 1'b1;
        ready_n_next = 1'b0;
        p_state_next = P_RHOLD;
      end
      P_DSWR: begin
        // Data sampled until the rising strobe, then committed
        ready_n_next = 1'b0;
        if (par_s.rds_n || par_s.cs_n) begin
          p_wr_req     = 1'b1;
          ready_n_next = 1'b1;
          p_state_next = P_IDLE;
        end else begin
          p_wdata_next = par_s.ad;
        end
      end
      P_RHOLD, P_WHOLD: begin
        if (!strobe_on) begin
          ad_oe_next   = 1'b0;
          ready_n_next = 1'b1;
          p_state_next = P_IDLE;
        end
      end
      default: p_state_next = P_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      p_state_reg <= P_IDLE;
      p_addr_reg  <= '0;
      p_wdata_reg <= '0;
      o_ad        <= '0;
      o_ad_oe     <= 1'b0;
      o_ready_n   <= 1'b1;
    end else if (i_clk_en) begin
      p_state_reg <= p_state_next;
      p_addr_reg  <= p_addr_next;
      p_wdata_reg <= p_wdata_next;
      o_ad        <= ad_next;
      o_ad_oe     <= ad_oe_next;
      o_ready_n   <= ready_n_next;
    end
  end

  // ----------------------------------------------------------------------
  // SPI slave
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {S_HDR, S_BODY, S_DONE} hpi_spi_state_t;
  hpi_spi_state_t        s_state_reg, s_state_next;
  logic [4:0]            cnt_reg, cnt_next;
  logic [23:0]           frame_reg, frame_next;
  logic [1:0]            fetch_reg, fetch_next;
  logic [hpi_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic                  sclk_d_reg, sdo_next, sdo_oe_next;
  logic                  s_rd_req, s_wr_req, lead, trail;
  logic                  sample_edge, shift_edge, lsb_first, rd_frame;

  // Edges seen from the sampled clock; it is never driven here
  assign lead  = spi_s.cpol ? (sclk_d_reg & ~spi_s.sclk)
                            : (~sclk_d_reg & spi_s.sclk);
  assign trail = spi_s.cpol ? (~sclk_d_reg & spi_s.sclk)
                            : (sclk_d_reg & ~spi_s.sclk);
  assign sample_edge = spi_s.cpha ? trail : lead;
  assign shift_edge  = spi_s.cpha ? lead : trail;
  assign lsb_first   = (style_reg == hpi_pkg::STYLE_SPI_LSB);
  assign rd_frame    = frame_reg[hpi_pkg::FRAME_READ_POS];

  // Frame: read flag, six spare bits, 9-bit address, then 8 data bits
  always_comb begin
    s_state_next = s_state_reg;
    cnt_next     = cnt_reg;
    frame_next   = frame_reg;
    fetch_next   = {fetch_reg[0], 1'b0};
    rdata_next   = fetch_reg[1] ? i_reg_rdata : rdata_reg;
    sdo_next     = o_sdo;
    sdo_oe_next  = o_sdo_oe;
    s_rd_req     = 1'b0;
    s_wr_req     = 1'b0;
    if (!spi_mode || par_s.cs_n) begin
      s_state_next = S_HDR;
      cnt_next     = 5'h00;
      sdo_oe_next  = 1'b0;
    end else begin
      if (sample_edge && s_state_reg != S_DONE) begin
        frame_next[bit_pos(cnt_reg, lsb_first)] = spi_s.sdi;
        cnt_next = cnt_reg + 5'h01;
      end
      if (shift_edge && rd_frame && s_state_reg == S_BODY) begin
        sdo_next = rdata_reg[lsb_first ? cnt_reg[2:0]
                                       : 3'h7 - cnt_reg[2:0]];
        sdo_oe_next = 1'b1;
      end
      case (s_state_reg)
        S_HDR: begin
          if (cnt_reg == hpi_pkg::HDR_BITS) begin
            s_rd_req     = rd_frame;
            fetch_next   = {fetch_reg[0], rd_frame};
            s_state_next = S_BODY;
          end
        end
        S_BODY: begin
          if (cnt_reg == hpi_pkg::FRAME_BITS) begin
            s_wr_req     = ~rd_frame;
            s_state_next = S_DONE;
          end
        end
        S_DONE: s_state_next = S_DONE;
        default: s_state_next = S_HDR;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_state_reg <= S_HDR;
      cnt_reg     <= 5'h00;
      frame_reg   <= '0;
      fetch_reg   <= 2'h0;
      rdata_reg   <= '0;
      sclk_d_reg  <= 1'b0;
      o_sdo       <= 1'b0;
      o_sdo_oe    <= 1'b0;
    end else if (i_clk_en) begin
      s_state_reg <= s_state_next;
      cnt_reg     <= cnt_next;
      frame_reg   <= frame_next;
      fetch_reg   <= fetch_next;
      rdata_reg   <= rdata_next;
      sclk_d_reg  <= spi_s.sclk;
      o_sdo       <= sdo_next;
      o_sdo_oe    <= sdo_oe_next;
    end
  end

  // ----------------------------------------------------------------------
  // Register side and interrupt pin
  // ----------------------------------------------------------------------
  logic irq_level;

  // Push-pull drives both levels; open-drain only pulls low
  always_comb begin
    irq_level = i_irq_pin_config.gpo_mode ? i_irq_pin_config.gpo_level
              : ~(i_irq_event ^ i_irq_pin_config.active_high);
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_addr   <= '0;
      o_reg_wdata  <= '0;
      o_reg_wr     <= 1'b0;
      o_reg_rd     <= 1'b0;
      o_irq_output <= 1'b0;
      o_irq_oe     <= 1'b0;
      o_bus_style  <= 3'h0;
    end else if (i_clk_en) begin
      o_reg_addr  <= spi_mode
                   ? frame_reg[hpi_pkg::FRAME_ADDR_LSB +: hpi_pkg::ADDR_W]
                   : p_addr_next;
      o_reg_wdata <= spi_mode ? frame_next[7:0] : p_wdata_next;
      o_reg_wr    <= p_wr_req | s_wr_req;
      o_reg_rd    <= p_rd_req | s_rd_req;
      o_irq_output <= ~i_irq_pin_config.open_drain & irq_level;
      o_irq_oe     <= ~i_irq_pin_config.open_drain | ~irq_level;
      o_bus_style  <= style_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence read_asked;
    o_reg_rd && !spi_mode;
  endsequence
  sequence read_answered;
    ##2 (!o_ready_n && o_ad_oe);
  endsequence
  chk_read_completes: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n || !i_clk_en) read_asked |-> read_answered)
    else $error("read not completed two cycles after request");
  chk_ad_drive_only: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n || !i_clk_en)
    o_ad_oe |-> (p_state_reg == P_RHOLD))
    else $error("shared pins driven outside a read");
  chk_sdo_release: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n || !i_clk_en) par_s.cs_n |=> !o_sdo_oe)
    else $error("serial output driven while deselected");
  chk_cnt_restart: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n || !i_clk_en) par_s.cs_n |=> cnt_reg == 5'h00)
    else $error("bit counter kept across deselect");
  chk_sample_edge: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n || !i_clk_en)
    (cnt_reg != 5'h00 && cnt_reg != $past(cnt_reg)) |-> $past(sample_edge))
    else $error("bit counted off the sampling edge");
  chk_ds_write_rise: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n || !i_clk_en)
    (o_reg_wr && ds_mode) |-> $past(p_state_reg) == P_DSWR)
    else $error("data strobe write without strobe release");
  chk_wr_single: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n || !i_clk_en) o_reg_wr |=> !o_reg_wr)
    else $error("write pulse longer than one cycle");
  chk_style_frozen: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n || !i_clk_en)
    strap_cnt_reg == hpi_pkg::STRAP_WAIT |=> $stable(style_reg))
    else $error("bus style changed after capture");
  chk_irq_drain: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n || !i_clk_en)
    $past(i_irq_pin_config.open_drain) |-> !o_irq_output)
    else $error("open-drain interrupt pin drove high");
  chk_irq_level: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n || !i_clk_en)
    ($past(i_reset_n) && $past(i_clk_en) &&
     !$past(i_irq_pin_config.gpo_mode) &&
     !$past(i_irq_pin_config.open_drain))
    |-> o_irq_output == ($past(i_irq_event) ^
                         !$past(i_irq_pin_config.active_high)))
    else $error("interrupt pin level wrong for polarity");
endmodule : hpi_host_port

// [hpi_pkg.sv]
// Package for the host processor port: bus styles, SPI framing, carriers.
// Assumes one 125 MHz core clock; pins arrive from outside its domain.
package hpi_pkg;
  // ----------------------------------------------------------------------
  // Bus styles caught from the select straps
  // ----------------------------------------------------------------------
  localparam logic [2:0] STYLE_SEP_MUX = 3'h2;
  localparam logic [2:0] STYLE_SEP_DIR = 3'h3;
  localparam logic [2:0] STYLE_DS_DIR  = 3'h4;
  localparam logic [2:0] STYLE_SPI_LSB = 3'h5;
  localparam logic [2:0] STYLE_DS_MUX  = 3'h6;
  localparam logic [2:0] STYLE_SPI_MSB = 3'h7;
  // ----------------------------------------------------------------------
  // Widths, counts and serial frame layout
  // ----------------------------------------------------------------------
  localparam int ADDR_W      = 9;
  localparam int DATA_W      = 8;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [4:0] HDR_BITS   = 5'h10;
  localparam logic [4:0] FRAME_BITS = 5'h18;
  localparam int FRAME_READ_POS = 23;
  localparam int FRAME_ADDR_LSB = 8;
  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic              cs_n;
    logic              wr_n;
    logic              rds_n;
    logic              ale;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] ad;
  } hpi_par_pins_t;
  typedef struct packed {
    logic sclk;
    logic sdi;
    logic cpha;
    logic cpol;
  } hpi_spi_pins_t;
  typedef struct packed {
    logic active_high;
    logic open_drain;
    logic gpo_mode;
    logic gpo_level;
  } hpi_irq_cfg_t;
endpackage : hpi_pkg

// [hpi_sync.sv]
// Two-stage synchroniser for a vector of pin inputs.
// Assumes each bit is a slow level; no bus coherency is promised.
`timescale 1ns/1ps
module hpi_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_mclk,
  input  wire logic             i_reset_n,
  input  wire logic             i_clk_en,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  // ----------------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // First stage is read only by the second
  always_comb begin
    meta_next = i_async;
    sync_next = meta_reg;
  end

  // Constant reset values only
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else if (i_clk_en) begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg;
endmodule : hpi_sync

// [hpi_host_model.sv]
// Host processor model: parallel strobe master and SPI master.
// Assumes the port under test answers with an active-low ready level.
`timescale 1ns/1ps
module hpi_host_model (
  input  wire logic                   i_mclk,
  input  wire logic                   i_ready_n,
  input  wire logic [7:0]             i_ad,
  input  wire logic                   i_ad_oe,
  input  wire logic                   i_sdo,
  output hpi_pkg::hpi_par_pins_t      o_par,
  output hpi_pkg::hpi_spi_pins_t      o_spi
);
  // Extra cycles a slow host holds its strobe after ready
  int stretch = 0;

  // Idle: deselected, strobes high, latch transparent
  initial begin
    o_par = '1;
    o_spi = '0;
  end

  // ----------------------------------------------------------------------
  // Parallel cycles
  // ----------------------------------------------------------------------
  // Bounded wait; a missing answer shows up as wrong data at the bench
  task automatic wait_rdy(input logic lvl);
    int n;
    n = 0;
    while (i_ready_n !== lvl && n < 64) begin
      @(posedge i_mclk);
      n++;
    end
  endtask : wait_rdy

  // Address settles one cycle ahead of the strobe so it is synced first
  task automatic par_write(input logic [8:0] addr, input logic [7:0] data);
    o_par.addr = addr;
    o_par.ad = data;
    o_par.cs_n = 1'b0;
    @(posedge i_mclk);
    #1 o_par.wr_n = 1'b0;
    wait_rdy(1'b0);
    repeat (stretch) @(posedge i_mclk);
    #1 o_par.wr_n = 1'b1;
    o_par.cs_n = 1'b1;
    o_par.ad = ~data; // Released lines show no stale value
    wait_rdy(1'b1);
    @(posedge i_mclk);
    #1;
  endtask : par_write

  task automatic par_read(input logic [8:0] addr, output logic [7:0] data,
                          output logic oe);
    o_par.addr = addr;
    o_par.cs_n = 1'b0;
    @(posedge i_mclk);
    #1 o_par.rds_n = 1'b0;
    wait_rdy(1'b0);
    data = i_ad;
    oe = i_ad_oe;
    repeat (stretch) @(posedge i_mclk);
    #1 o_par.rds_n = 1'b1;
    o_par.cs_n = 1'b1;
    wait_rdy(1'b1);
    @(posedge i_mclk);
    #1;
  endtask : par_read

  // Data strobe cycle with a multiplexed address phase; the unused
  // address pins carry the inverse so a wrong latch source shows up
  task automatic ds_cycle(input logic [8:0] addr, input logic rnw,
                          input logic [7:0] wdata, output logic [7:0] data);
    o_par.addr = {addr[8], ~addr[7:0]};
    o_par.ad = addr[7:0];
    o_par.ale = 1'b1;
    o_par.wr_n = rnw;
    @(posedge i_mclk);
    #1 o_par.ale = 1'b0;
    o_par.ad = wdata;
    o_par.cs_n = 1'b0;
    @(posedge i_mclk);
    #1 o_par.rds_n = 1'b0;
    wait_rdy(1'b0);
    data = i_ad;
    repeat (4) @(posedge i_mclk);
    #1 o_par.rds_n = 1'b1;
    o_par.cs_n = 1'b1;
    o_par.ad = ~wdata;
    wait_rdy(1'b1);
    @(posedge i_mclk);
    #1;
  endtask : ds_cycle

  // ----------------------------------------------------------------------
  // SPI frames, half period 80 ns; clock still outside frames
  // ----------------------------------------------------------------------
  task automatic spi_xfer(input logic cpol, input logic cpha,
                          input logic [23:0] frame, input int nbits,
                          output logic [7:0] rd);
    rd = 8'h00;
    o_spi.cpol = cpol;
    o_spi.cpha = cpha;
    o_spi.sclk = cpol;
    #200 o_par.cs_n = 1'b0;
    #200;
    for (int i = 0; i < nbits; i++) begin
      if (!cpha) o_spi.sdi = frame[23-i];
      #80 o_spi.sclk = ~cpol;
      if (cpha) o_spi.sdi = frame[23-i];
      else if (i >= 16) rd = {rd[6:0], i_sdo};
      #80 o_spi.sclk = cpol;
      if (cpha && i >= 16) rd = {rd[6:0], i_sdo};
    end
    #200 o_par.cs_n = 1'b1;
    o_spi.sdi = ~o_spi.sdi;
    #200;
  endtask : spi_xfer
endmodule : hpi_host_model

// [hpi_host_port_test.sv]
// Self-checking bench for the host port: parallel, SPI and interrupt pin.
// Assumes hpi_host_model drives the pins; the bench plays the registers.
`timescale 1ns/1ps
module hpi_host_port_test;
  logic                   i_mclk;
  logic                   i_reset_n;
  logic [2:0]             strap;
  hpi_pkg::hpi_par_pins_t par;
  hpi_pkg::hpi_spi_pins_t spi;
  hpi_pkg::hpi_irq_cfg_t  irq_cfg;
  logic                   irq_event;
  logic [7:0]             rdata;
  logic [2:0]             bus_style;
  logic [7:0]             ad;
  logic                   ad_oe, ready_n, sdo, sdo_oe, irq_out, irq_oe;
  logic [8:0]             reg_addr;
  logic [7:0]             reg_wdata;
  logic                   reg_wr, reg_rd;
  logic [16:0]            last_wr;
  logic [8:0]             last_rd;
  int                     n_fail = 0;
  int                     n_compared = 0;
  int                     n_wr = 0;

  hpi_host_port DUT (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_clk_en(1'b1),
    .i_bus_style_select(strap), .i_par(par), .i_spi(spi),
    .i_irq_pin_config(irq_cfg), .i_irq_event(irq_event),
    .i_reg_rdata(rdata), .o_bus_style(bus_style), .o_ad(ad),
    .o_ad_oe(ad_oe), .o_ready_n(ready_n), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
    .o_irq_output(irq_out), .o_irq_oe(irq_oe), .o_reg_addr(reg_addr),
    .o_reg_wdata(reg_wdata), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd));

  hpi_host_model HOST (
    .i_mclk(i_mclk), .i_ready_n(ready_n), .i_ad(ad), .i_ad_oe(ad_oe),
    .i_sdo(sdo), .o_par(par), .o_spi(spi));

  // 125 MHz core clock
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  // Register side: record every write and read strobe
  always @(posedge i_mclk) begin
    if (reg_wr === 1'b1) begin
      last_wr <= {reg_addr, reg_wdata};
      n_wr <= n_wr + 1;
    end
    if (reg_rd === 1'b1) last_rd <= reg_addr;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("n_compared=%0d n_fail=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  // Straps must be steady across release for the capture window
  task automatic do_reset(input logic [2:0] style);
    i_reset_n = 1'b0;
    strap = style;
    repeat (20) @(posedge i_mclk);
    #1 i_reset_n = 1'b1;
    repeat (12) @(posedge i_mclk);
    #1;
    chk(24'(bus_style), 24'(style));
    chk(24'({ready_n, ad_oe, sdo_oe}), 24'h4);
  endtask : do_reset

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Back-to-back writes at both address extremes, fast then slow host
  task automatic test_par_write;
    int n0;
    n0 = n_wr;
    HOST.par_write(9'h1ff, 8'h5a);
    chk(24'(last_wr), 24'({9'h1ff, 8'h5a}));
    HOST.stretch = 5;
    HOST.par_write(9'h000, 8'hc3);
    HOST.stretch = 0;
    chk(24'(last_wr), 24'({9'h000, 8'hc3}));
    chk(24'(n_wr - n0), 24'd2);
  endtask : test_par_write

  // Read returns register data on the shared pins, then lets go
  task automatic test_par_read;
    logic [7:0] d;
    logic       oe;
    rdata = 8'ha5;
    HOST.par_read(9'h10b, d, oe);
    chk(24'({oe, d}), 24'h1a5);
    chk(24'(last_rd), 24'h10b);
    chk(24'({ready_n, ad_oe}), 24'h2);
  endtask : test_par_read

  // Every polarity, drive and output-mode setting against both events
  task automatic test_irq;
    logic lvl;
    for (int k = 0; k < 32; k++) begin
      irq_cfg = hpi_pkg::hpi_irq_cfg_t'(k[3:0]);
      irq_event = k[4];
      repeat (2) @(posedge i_mclk);
      #1;
      lvl = irq_cfg.gpo_mode ? irq_cfg.gpo_level
                             : (irq_cfg.active_high ? irq_event : ~irq_event);
      chk(24'({irq_out, irq_oe}),
          irq_cfg.open_drain ? 24'({1'b0, ~lvl}) : 24'({lvl, 1'b1}));
    end
  endtask : test_irq

  // Data strobe style, multiplexed address: write then read
  task automatic test_ds_mux;
    logic [7:0] d;
    do_reset(hpi_pkg::STYLE_DS_MUX);
    HOST.ds_cycle(9'h1c4, 1'b0, 8'h69, d);
    chk(24'(last_wr), 24'({9'h1c4, 8'h69}));
    rdata = 8'h3e;
    HOST.ds_cycle(9'h03b, 1'b1, 8'h00, d);
    chk(24'({last_rd, d}), 24'({9'h03b, 8'h3e}));
  endtask : test_ds_mux

  // Aborted frame, then a write and a read in opposite clock modes
  task automatic test_spi;
    logic [7:0] d;
    int         n0;
    n0 = n_wr;
    HOST.spi_xfer(1'b0, 1'b0, {1'b0, 6'h00, 9'h0f0, 8'hff}, 10, d);
    HOST.spi_xfer(1'b0, 1'b0, {1'b0, 6'h00, 9'h155, 8'h3c}, 24, d);
    chk(24'(last_wr), 24'({9'h155, 8'h3c}));
    chk(24'(n_wr - n0), 24'd1);
    rdata = 8'h96;
    HOST.spi_xfer(1'b1, 1'b1, {1'b1, 6'h00, 9'h0aa, 8'h00}, 24, d);
    chk(24'({last_rd, d}), 24'({9'h0aa, 8'h96}));
    chk(24'(sdo_oe), 24'h0);
    HOST.spi_xfer(1'b1, 1'b0, {1'b1, 6'h00, 9'h001, 8'h00}, 24, d);
    chk(24'(d), 24'h96);
    // Fields sent low bit first: address 0c5, data 2d, write
    do_reset(hpi_pkg::STYLE_SPI_LSB);
    HOST.spi_xfer(1'b0, 1'b1, 24'ha3_00b4, 24, d);
    chk(24'(last_wr), 24'({9'h0c5, 8'h2d}));
  endtask : test_spi

  // Main sequence
  initial begin
    i_reset_n = 1'b0;
    strap = hpi_pkg::STYLE_SEP_DIR;
    irq_cfg = '0;
    irq_event = 1'b0;
    rdata = 8'h00;
    do_reset(hpi_pkg::STYLE_SEP_DIR);
    test_par_write();
    test_par_read();
    test_irq();
    test_ds_mux();
    do_reset(hpi_pkg::STYLE_SPI_MSB);
    test_spi();
    stop_test();
  end

  // Watchdog: the run needs well under 50 k cycles
  initial begin
    #400000;
    n_fail++;
    stop_test();
  end
endmodule : hpi_host_port_test
